// ---- common/fsc_params.svh ----
// fsc_params.svh: constants of the static frame classifier
// assumes inclusion by the package and the design files
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH
// --------------------------------------------------
// header capture
// --------------------------------------------------
`define FSC_HDR_BYTES 30
`define FSC_HDR_BITS 240
`define FSC_HDR_LAST 5'h1D
`define FSC_OFF_ET1 12
`define FSC_TAG_LEN 4
// --------------------------------------------------
// ethertypes and tag bits
// --------------------------------------------------
`define FSC_ET_SECTAG 16'h88E5
`define FSC_ET_QTAG 16'h8100
`define FSC_ET_STAG 16'h88A8
`define FSC_TCI_V 7
`define FSC_TCI_ES 6
`define FSC_TCI_SC 5
`define FSC_TCI_SCB 4
`define FSC_TCI_E 3
`define FSC_TCI_C 2
`define FSC_SL_LIMIT 8'h30
// --------------------------------------------------
// register word indices
// --------------------------------------------------
`define FSC_R_FULL_LO 6'h00
`define FSC_R_FULL_HI 6'h01
`define FSC_R_PFX_LO 6'h02
`define FSC_R_PFX_HI 6'h03
`define FSC_R_RLO_LO 6'h04
`define FSC_R_RLO_HI 6'h05
`define FSC_R_RHI_LO 6'h06
`define FSC_R_RHI_HI 6'h07
`define FSC_R_ENABLES 6'h08
`define FSC_R_ETSEL 6'h09
`define FSC_R_TAGCHK 6'h0A
`define FSC_R_VLANTAG 6'h0B
`define FSC_R_VPRIO 6'h0C
`define FSC_R_REMAP 6'h0D
`define FSC_R_STATUS 6'h0E
`define FSC_R_ENTRY 6'h10
`define FSC_R_ETB 6'h24
// --------------------------------------------------
// enable bit layout
// --------------------------------------------------
`define FSC_EN_DA 0
`define FSC_EN_ETA 8
`define FSC_EN_ETB 16
`define FSC_EN_PAIR 24
`define FSC_EN_FULL 26
`define FSC_EN_PFX 27
`define FSC_EN_RANGE 28
`define FSC_SEL_ETB 10
// --------------------------------------------------
// reset values
// --------------------------------------------------
`define FSC_RST_FULL 48'h01000CCCCCCC
`define FSC_RST_PFX 48'h0180C2000000
`define FSC_RST_VLANTAG 2'h3
`endif

// ---- common/fsc_pkg.sv ----
// fsc_pkg: types of the static frame classifier
// assumes fsc_params.svh on the include path
`include "fsc_params.svh"
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_UNTAGGED = 2'b00,
    FSC_TAGGED = 2'b01,
    FSC_BAD_TAG = 2'b10,
    FSC_KAY = 2'b11
  } fsc_tag_class_t;

  typedef enum logic [1:0] {
    FSC_IDLE = 2'b00,
    FSC_CAPT = 2'b01,
    FSC_SKIP = 2'b10
  } fsc_cap_state_t;

  typedef struct packed {
    fsc_cap_state_t state;
    logic [4:0] cnt;
    logic [`FSC_HDR_BITS-1:0] hdr;
    logic done;
  } fsc_cap_t;

  typedef struct packed {
    logic [47:0] full_addr;
    logic [47:0] pfx_addr;
    logic [47:0] range_low;
    logic [47:0] range_high;
    logic [9:0][47:0] entry_addr;
    logic [9:0][15:0] entry_type;
    logic [7:0][15:0] etb_type;
    logic [28:0] enables;
    logic [17:0] et_select;
    logic tag_bypass;
    logic [1:0] vlan_tag;
    logic [3:0] vlan_prio;
    logic [23:0] remap;
    logic bus_wait;
    logic [31:0] rd_data;
    logic res_valid;
    logic ctl_frame;
    fsc_tag_class_t tag_class;
    logic kay_bypass;
    logic vlan_valid;
    logic stag_valid;
    logic qtag_valid;
    logic qinq_found;
    logic [2:0] outer_up;
    logic [11:0] outer_vid;
    logic [2:0] inner_up;
    logic [11:0] inner_vid;
    logic [15:0] parsed_et;
  } fsc_state_t;
endpackage

// ---- verilog/fsc_hdr_capture.sv ----
// fsc_hdr_capture: keeps the first header bytes of each frame
// assumes a byte stream with start and end marks on clk
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_hdr_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  output logic [`FSC_HDR_BITS-1:0] hdr,
  output logic hdr_done
);
  import fsc_pkg::*;

  fsc_cap_t q;
  fsc_cap_t next_q;

  // --------------------------------------------------
  // capture sequence
  // --------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    if (rx_valid && rx_sop) begin
      next_q.hdr = '0;
      next_q.hdr[`FSC_HDR_BITS-1 -: 8] = rx_data;
      next_q.cnt = 5'h01;
      next_q.done = rx_eop;
      next_q.state = rx_eop ? FSC_IDLE : FSC_CAPT;
    end else if (rx_valid) begin
      case (q.state)
        FSC_CAPT: begin
          next_q.hdr[`FSC_HDR_BITS-1-8*q.cnt -: 8] = rx_data;
          next_q.cnt = q.cnt + 5'h01;
          if (rx_eop || q.cnt == `FSC_HDR_LAST) begin
            next_q.done = 1'b1;
            next_q.state = rx_eop ? FSC_IDLE : FSC_SKIP;
          end
        end
        FSC_SKIP: begin
          if (rx_eop) begin
            next_q.state = FSC_IDLE;
          end
        end
        default: begin
          next_q.state = FSC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign hdr = q.hdr;
  assign hdr_done = q.done;
endmodule
`default_nettype wire

// ---- verilog/fsc_classifier.sv ----
// fsc_classifier: static classification of frame headers
// assumes an avalon-mm master with waitrequest and a mac byte stream
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_classifier (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  output logic res_valid,
  output logic ctl_frame,
  output fsc_pkg::fsc_tag_class_t tag_class,
  output logic kay_bypass,
  output logic vlan_valid,
  output logic stag_valid,
  output logic qtag_valid,
  output logic qinq_found,
  output logic [2:0] outer_up,
  output logic [11:0] outer_vid,
  output logic [2:0] inner_up,
  output logic [11:0] inner_vid,
  output logic [15:0] parsed_et
);
  import fsc_pkg::*;

  fsc_state_t q;
  fsc_state_t next_q;
  logic [`FSC_HDR_BITS-1:0] hdr;
  logic hdr_done;

  fsc_hdr_capture u_capture (
    .clk(clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_sop(rx_sop),
    .rx_eop(rx_eop),
    .hdr(hdr),
    .hdr_done(hdr_done)
  );

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic [7:0] hbyte(input logic [`FSC_HDR_BITS-1:0] h, input int i);
    return h[`FSC_HDR_BITS-1-8*i -: 8];
  endfunction

  function automatic logic [15:0] hword(input logic [`FSC_HDR_BITS-1:0] h, input int i);
    return {hbyte(h, i), hbyte(h, i + 1)};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_vlan(input logic [15:0] et, input logic [1:0] ena);
    return (ena[0] && et == `FSC_ET_QTAG) || (ena[1] && et == `FSC_ET_STAG);
  endfunction

  // checks taken in a fixed order, first hit decides
  function automatic fsc_tag_class_t tag_check(input logic [15:0] et, input logic [7:0] tci,
                                               input logic [7:0] sl, input logic [31:0] pn);
    if (et != `FSC_ET_SECTAG) begin
      return FSC_UNTAGGED;
    end else if (tci[`FSC_TCI_V]) begin
      return FSC_BAD_TAG;
    end else if (!tci[`FSC_TCI_C] && tci[`FSC_TCI_E]) begin
      return FSC_KAY;
    end else if (tci[`FSC_TCI_C] && !tci[`FSC_TCI_E]) begin
      return FSC_BAD_TAG;
    end else if (tci[`FSC_TCI_SC] && (tci[`FSC_TCI_ES] || tci[`FSC_TCI_SCB])) begin
      return FSC_BAD_TAG;
    end else if (sl >= `FSC_SL_LIMIT) begin
      return FSC_BAD_TAG;
    end else if (pn == 32'h0000_0000) begin
      return FSC_BAD_TAG;
    end
    return FSC_TAGGED;
  endfunction

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb begin
    logic [47:0] da;
    logic [15:0] et_first;
    logic [15:0] et_mid;
    logic [15:0] et_cmp;
    logic [15:0] tag1;
    logic [15:0] tag2;
    logic v1;
    logic v2;
    logic ctl;
    int tag_off;
    int idx;
    logic [31:0] w;
    da = '0;
    et_first = '0;
    et_mid = '0;
    et_cmp = '0;
    tag1 = '0;
    tag2 = '0;
    v1 = 1'b0;
    v2 = 1'b0;
    ctl = 1'b0;
    tag_off = 0;
    idx = 0;
    w = '0;
    next_q = q;
    next_q.res_valid = 1'b0;

    // bus slave: one wait cycle, write lands on the answer edge
    next_q.bus_wait = 1'b1;
    if (avs_read || avs_write) begin
      next_q.bus_wait = !q.bus_wait;
      case (avs_address)
        `FSC_R_FULL_LO: w = q.full_addr[31:0];
        `FSC_R_FULL_HI: w = {16'h0000, q.full_addr[47:32]};
        `FSC_R_PFX_LO: w = q.pfx_addr[31:0];
        `FSC_R_PFX_HI: w = {16'h0000, q.pfx_addr[47:32]};
        `FSC_R_RLO_LO: w = q.range_low[31:0];
        `FSC_R_RLO_HI: w = {16'h0000, q.range_low[47:32]};
        `FSC_R_RHI_LO: w = q.range_high[31:0];
        `FSC_R_RHI_HI: w = {16'h0000, q.range_high[47:32]};
        `FSC_R_ENABLES: w = {3'h0, q.enables};
        `FSC_R_ETSEL: w = {14'h0000, q.et_select};
        `FSC_R_TAGCHK: w = {31'h0000_0000, q.tag_bypass};
        `FSC_R_VLANTAG: w = {30'h0000_0000, q.vlan_tag};
        `FSC_R_VPRIO: w = {28'h000_0000, q.vlan_prio};
        `FSC_R_REMAP: w = {8'h00, q.remap};
        `FSC_R_STATUS: w = {q.parsed_et, 4'h0, q.qinq_found, q.qtag_valid, q.stag_valid,
                            q.vlan_valid, 5'h00, q.tag_class, q.ctl_frame};
        default: w = '0;
      endcase
      for (int i = 0; i < 10; i++) begin
        if (avs_address == `FSC_R_ENTRY + 6'(2 * i)) begin
          w = q.entry_addr[i][31:0];
        end
        if (avs_address == `FSC_R_ENTRY + 6'(2 * i + 1)) begin
          w = {q.entry_type[i], q.entry_addr[i][47:32]};
        end
      end
      for (int i = 0; i < 8; i++) begin
        if (avs_address == `FSC_R_ETB + 6'(i)) begin
          w = {16'h0000, q.etb_type[i]};
        end
      end
      if (q.bus_wait) begin
        next_q.rd_data = avs_read ? w : '0;
      end
      if (avs_write && !q.bus_wait) begin
        case (avs_address)
          `FSC_R_FULL_LO: next_q.full_addr[31:0] = wmerge(w, avs_writedata, avs_byteenable);
          `FSC_R_FULL_HI: next_q.full_addr[47:32] =
            16'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_PFX_LO: next_q.pfx_addr[31:0] = wmerge(w, avs_writedata, avs_byteenable);
          `FSC_R_PFX_HI: next_q.pfx_addr[47:32] =
            16'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_RLO_LO: next_q.range_low[31:0] = wmerge(w, avs_writedata, avs_byteenable);
          `FSC_R_RLO_HI: next_q.range_low[47:32] =
            16'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_RHI_LO: next_q.range_high[31:0] = wmerge(w, avs_writedata, avs_byteenable);
          `FSC_R_RHI_HI: next_q.range_high[47:32] =
            16'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_ENABLES: next_q.enables = 29'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_ETSEL: next_q.et_select = 18'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_TAGCHK: next_q.tag_bypass = avs_byteenable[0] ? avs_writedata[0] : q.tag_bypass;
          `FSC_R_VLANTAG: next_q.vlan_tag = 2'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_VPRIO: next_q.vlan_prio = 4'(wmerge(w, avs_writedata, avs_byteenable));
          `FSC_R_REMAP: next_q.remap = 24'(wmerge(w, avs_writedata, avs_byteenable));
          default: next_q.remap = q.remap;
        endcase
        for (int i = 0; i < 10; i++) begin
          if (avs_address == `FSC_R_ENTRY + 6'(2 * i)) begin
            next_q.entry_addr[i][31:0] = wmerge(w, avs_writedata, avs_byteenable);
          end
          if (avs_address == `FSC_R_ENTRY + 6'(2 * i + 1)) begin
            {next_q.entry_type[i], next_q.entry_addr[i][47:32]} =
              wmerge(w, avs_writedata, avs_byteenable);
          end
        end
        for (int i = 0; i < 8; i++) begin
          if (avs_address == `FSC_R_ETB + 6'(i)) begin
            next_q.etb_type[i] = 16'(wmerge(w, avs_writedata, avs_byteenable));
          end
        end
      end
    end

    // vlan parsing
    da = {hword(hdr, 0), hword(hdr, 2), hword(hdr, 4)};
    et_first = hword(hdr, `FSC_OFF_ET1);
    v1 = is_vlan(et_first, q.vlan_tag);
    et_mid = hword(hdr, `FSC_OFF_ET1 + `FSC_TAG_LEN);
    v2 = v1 && is_vlan(et_mid, q.vlan_tag);
    tag1 = hword(hdr, `FSC_OFF_ET1 + 2);
    tag2 = hword(hdr, `FSC_OFF_ET1 + 2 + `FSC_TAG_LEN);
    tag_off = `FSC_OFF_ET1;
    if (q.tag_bypass && v2) begin
      tag_off = `FSC_OFF_ET1 + 2 * `FSC_TAG_LEN;
    end else if (q.tag_bypass && v1) begin
      tag_off = `FSC_OFF_ET1 + `FSC_TAG_LEN;
    end

    // control criteria
    if (q.enables[`FSC_EN_FULL] && da == q.full_addr) begin
      ctl = 1'b1;
    end
    if (q.enables[`FSC_EN_PFX] && da[47:4] == q.pfx_addr[47:4]) begin
      ctl = 1'b1;
    end
    if (q.enables[`FSC_EN_RANGE] && da >= q.range_low && da <= q.range_high) begin
      ctl = 1'b1;
    end
    for (int i = 0; i < 10; i++) begin
      et_cmp = q.et_select[i] ? (v2 ? hword(hdr, `FSC_OFF_ET1 + 2 * `FSC_TAG_LEN) :
                                 (v1 ? et_mid : et_first)) : et_first;
      if (i < 8) begin
        if (q.enables[`FSC_EN_DA + i] && da == q.entry_addr[i]) begin
          ctl = 1'b1;
        end
        if (q.enables[`FSC_EN_ETA + i] && et_cmp == q.entry_type[i]) begin
          ctl = 1'b1;
        end
      end else if (q.enables[`FSC_EN_PAIR + i - 8] && da == q.entry_addr[i] &&
                   et_cmp == q.entry_type[i]) begin
        ctl = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      et_cmp = q.et_select[`FSC_SEL_ETB + i] ?
               (v2 ? hword(hdr, `FSC_OFF_ET1 + 2 * `FSC_TAG_LEN) :
                (v1 ? et_mid : et_first)) : et_first;
      if (q.enables[`FSC_EN_ETB + i] && et_cmp == q.etb_type[i]) begin
        ctl = 1'b1;
      end
    end

    // results at header completion
    if (hdr_done) begin
      next_q.res_valid = 1'b1;
      next_q.ctl_frame = ctl;
      next_q.tag_class = tag_check(hword(hdr, tag_off), hbyte(hdr, tag_off + 2),
                                   hbyte(hdr, tag_off + 3),
                                   {hword(hdr, tag_off + 4), hword(hdr, tag_off + 6)});
      next_q.kay_bypass = next_q.tag_class == FSC_KAY;
      next_q.vlan_valid = v1;
      next_q.stag_valid = v1 && et_first == `FSC_ET_STAG;
      next_q.qtag_valid = v1 && et_first == `FSC_ET_QTAG;
      next_q.qinq_found = v2;
      next_q.outer_up = (v1 && q.vlan_prio[0]) ? tag1[15:13] : q.vlan_prio[3:1];
      next_q.outer_vid = tag1[11:0];
      idx = int'(tag2[15:13]);
      next_q.inner_up = q.remap[3 * idx +: 3];
      next_q.inner_vid = tag2[11:0];
      next_q.parsed_et = v2 ? hword(hdr, `FSC_OFF_ET1 + 2 * `FSC_TAG_LEN) :
                         (v1 ? et_mid : et_first);
    end
  end

  // --------------------------------------------------
  // state register
  // --------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.full_addr <= `FSC_RST_FULL;
      q.pfx_addr <= `FSC_RST_PFX;
      q.enables <= '0;
      q.vlan_tag <= `FSC_RST_VLANTAG;
      q.bus_wait <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign avs_readdata = q.rd_data;
  assign avs_waitrequest = q.bus_wait;
  assign res_valid = q.res_valid;
  assign ctl_frame = q.ctl_frame;
  assign tag_class = q.tag_class;
  assign kay_bypass = q.kay_bypass;
  assign vlan_valid = q.vlan_valid;
  assign stag_valid = q.stag_valid;
  assign qtag_valid = q.qtag_valid;
  assign qinq_found = q.qinq_found;
  assign outer_up = q.outer_up;
  assign outer_vid = q.outer_vid;
  assign inner_up = q.inner_up;
  assign inner_vid = q.inner_vid;
  assign parsed_et = q.parsed_et;
endmodule
`default_nettype wire

// ---- tb/fsc_mac_model.sv ----
// fsc_mac_model: mac byte source feeding the classifier
// assumes send is called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module fsc_mac_model (
  input wire logic clk,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  output var logic rx_sop,
  output var logic rx_eop
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_sop = 1'b0;
    rx_eop = 1'b0;
  end
  // ----
  // one frame, optional gap after byte 2
  // ----
  task automatic send(input logic [7:0] b [64], input int n, input bit g);
    for (int k = 0; k < n; k++) begin
      if (g && k == 3) begin
        rx_valid <= 1'b0;
        rx_sop <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge clk);
      end
      rx_valid <= 1'b1;
      rx_data <= b[k];
      rx_sop <= k == 0;
      rx_eop <= k == n - 1;
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_sop <= 1'b0;
    rx_eop <= 1'b0;
    rx_data <= ~b[n - 1];
  endtask
endmodule
`default_nettype wire

// ---- tb/fsc_classifier_checker.sv ----
// fsc_classifier_checker: port assertions of the classifier
// assumes a bind to fsc_classifier, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_classifier_checker import fsc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_sop,
  input wire logic rx_eop,
  input wire logic res_valid,
  input wire logic ctl_frame,
  input wire fsc_pkg::fsc_tag_class_t tag_class,
  input wire logic kay_bypass,
  input wire logic vlan_valid,
  input wire logic stag_valid,
  input wire logic qtag_valid,
  input wire logic qinq_found,
  input wire logic [15:0] parsed_et
);
  logic [5:0] cnt;
  logic [15:0] et1;
  logic plain;
  // ----
  // shadow of the first ethertype
  // ----
  assign plain = et1 != `FSC_ET_SECTAG && et1 != `FSC_ET_QTAG && et1 != `FSC_ET_STAG;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
      et1 <= 16'h0000;
    end else if (rx_valid && rx_sop) begin
      cnt <= rx_eop ? 6'h00 : 6'h01;
      et1 <= 16'h0000;
    end else if (rx_valid && cnt != 6'h00) begin
      et1 <= cnt == 6'h0C ? {rx_data, et1[7:0]} : cnt == 6'h0D ? {et1[15:8], rx_data} : et1;
      cnt <= rx_eop ? 6'h00 : (cnt == 6'h1F ? cnt : cnt + 6'h01);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_kay;
    kay_bypass == (tag_class == FSC_KAY);
  endproperty
  a_kay: assert property (p_kay) else $error("kay bypass wrong");
  property p_untag;
    res_valid && plain |-> tag_class == FSC_UNTAGGED;
  endproperty
  a_untag: assert property (p_untag) else $error("class not untagged");
  property p_novlan;
    res_valid && plain |-> !vlan_valid && !qinq_found;
  endproperty
  a_novlan: assert property (p_novlan) else $error("vlan seen in plain frame");
  property p_pet;
    res_valid && plain |-> parsed_et == et1;
  endproperty
  a_pet: assert property (p_pet) else $error("parsed ethertype wrong");
  property p_flags;
    (vlan_valid == (stag_valid || qtag_valid)) && !(stag_valid && qtag_valid) &&
      (vlan_valid || !qinq_found);
  endproperty
  a_flags: assert property (p_flags) else $error("vlan flags inconsistent");
  property p_hold;
    $changed({ctl_frame, tag_class, parsed_et}) |-> res_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without res_valid");
  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer after one wait");
  property p_pulse;
    $fell(avs_waitrequest) |=> avs_waitrequest;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than a cycle");
endmodule
`default_nettype wire

// ---- tb/fsc_classifier_tb.sv ----
// fsc_classifier_tb: register and frame tests of the classifier
// assumes fsc_pkg, the mac model and the checker compiled before
`timescale 1ns/1ps
`default_nettype none
module fsc_classifier_tb;
  import fsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, rx_valid, rx_sop, rx_eop, res_valid, ctl_frame, kay_bypass;
  logic vlan_valid, stag_valid, qtag_valid, qinq_found;
  logic [7:0] rx_data;
  logic [2:0] outer_up, inner_up;
  logic [11:0] outer_vid, inner_vid;
  logic [15:0] parsed_et;
  fsc_tag_class_t tag_class;
  logic [7:0] f [64];
  int n_mismatch = 0;
  int samples_checked = 0;
  int i;
  logic [31:0] tt [11] = '{32'h0C000101, 32'h8C000102, 32'h88000102, 32'h08000003,
    32'h04000102, 32'h6C000102, 32'h3C000102, 32'h2C2F0101, 32'h0C300102, 32'h0C000002,
    32'h00000101};
  localparam logic [47:0] D = 48'h02CD00000000;
  always #12.5 clk = ~clk;
  fsc_classifier u_fsc_classifier (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_valid, .rx_data,
    .rx_sop, .rx_eop, .res_valid, .ctl_frame, .tag_class, .kay_bypass, .vlan_valid,
    .stag_valid, .qtag_valid, .qinq_found, .outer_up, .outer_vid, .inner_up, .inner_vid,
    .parsed_et);
  fsc_mac_model u_fsc_mac_model (.clk, .rx_valid, .rx_data, .rx_sop, .rx_eop);
  // ----
  // shared tasks
  // ----
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk({32'h0, q}, {32'h0, e});
  endtask
  task automatic p16(input int x, input logic [15:0] v);
    f[x] = v[15:8];
    f[x + 1] = v[7:0];
  endtask
  task automatic mk(input logic [47:0] da, input logic [15:0] et);
    for (int j = 0; j < 64; j++) f[j] = 8'(j + 32);
    for (int j = 0; j < 6; j++) f[j] = da[47 - 8 * j -: 8];
    p16(12, et);
  endtask
  task automatic fr(input int n, input bit g);
    int k;
    u_fsc_mac_model.send(f, n, g);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (res_valid !== 1'b1 && k < 8);
    if (res_valid !== 1'b1) n_mismatch++;
  endtask
  task automatic ctl(input logic [47:0] da, input logic [15:0] et, input logic e);
    mk(da, et);
    fr(30, 1'b0);
    chk({63'h0, ctl_frame}, {63'h0, e});
  endtask
  task automatic vchk(input logic [34:0] e);
    logic [11:0] v;
    v = e[34] ? outer_vid : e[27:16];
    chk({29'h0, vlan_valid, stag_valid, qtag_valid, qinq_found, outer_up, v, parsed_et},
      {29'h0, e});
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(6'h08, 32'h0);
    rd(6'h00, 32'h0CCCCCCC);
    rd(6'h01, 32'h00000100);
    rd(6'h02, 32'hC2000000);
    rd(6'h03, 32'h00000180);
    wr(6'h0F, 32'hFFFFFFFF);
    rd(6'h0F, 32'h0);
    wr(6'h0E, 32'hFFFFFFFF);
    rd(6'h0E, 32'h0);
    ctl(48'h01000CCCCCCC, 16'h888E, 1'b0);
    for (i = 0; i < 10; i++) begin
      wr(6'(16 + 2 * i), 32'(i));
      wr(6'(17 + 2 * i), {16'(16'h9000 + i), 16'h02AB});
    end
    for (i = 0; i < 8; i++) wr(6'(36 + i), 32'(16'hA000 + i));
    ctl(48'h02AB00000003, 16'h9003, 1'b0);
    wr(6'h08, 32'h03FFFFFF);
    for (i = 0; i < 8; i++) begin
      ctl({16'h02AB, 32'(i)}, 16'h0800, 1'b1);
      ctl(D, 16'(16'h9000 + i), 1'b1);
      ctl(D, 16'(16'hA000 + i), 1'b1);
    end
    for (i = 8; i < 10; i++) begin
      ctl({16'h02AB, 32'(i)}, 16'(16'h9000 + i), 1'b1);
      ctl({16'h02AB, 32'(i)}, 16'h0800, 1'b0);
      ctl(D, 16'(16'h9000 + i), 1'b0);
    end
    ctl(D, 16'h0800, 1'b0);
    wr(6'h08, 32'h04000000);
    ctl(48'h01000CCCCCCC, 16'h0800, 1'b1);
    ctl(48'h01000CCCCCCD, 16'h0800, 1'b0);
    wr(6'h00, 32'h56789ABC);
    wr(6'h01, 32'h00001234);
    ctl(48'h123456789ABC, 16'h0800, 1'b1);
    wr(6'h08, 32'h08000000);
    ctl(48'h0180C200000F, 16'h0800, 1'b1);
    ctl(48'h0180C2000010, 16'h0800, 1'b0);
    wr(6'h08, 32'h10000000);
    wr(6'h04, 32'h100);
    wr(6'h05, 32'h0);
    wr(6'h06, 32'h100);
    wr(6'h07, 32'h0);
    ctl(48'h000000000100, 16'h0800, 1'b1);
    ctl(48'h000000000101, 16'h0800, 1'b0);
    ctl(48'h0000000000FF, 16'h0800, 1'b0);
    wr(6'h06, 32'hFFFFFFFF);
    wr(6'h07, 32'h0000FFFF);
    wr(6'h04, 32'h0);
    ctl(48'hFFFFFFFFFFFF, 16'h0800, 1'b1);
    wr(6'h08, 32'h00010000);
    mk(D, 16'h8100);
    p16(14, 16'h0001);
    p16(16, 16'hA000);
    fr(30, 1'b0);
    chk({63'h0, ctl_frame}, 64'h0);
    wr(6'h09, 32'h00000400);
    fr(30, 1'b0);
    chk({63'h0, ctl_frame}, 64'h1);
    for (i = 0; i < 11; i++) begin
      mk(D, 16'h88E5);
      p16(14, tt[i][31:16]);
      p16(16, 16'h0000);
      p16(18, {8'h00, tt[i][15:8]});
      fr(30, i == 0);
      chk({61'h0, kay_bypass, tag_class},
        {61'h0, tt[i][1:0] == 2'h3, tt[i][1:0]});
    end
    mk(D, 16'h88E6);
    fr(14, 1'b0);
    chk({46'h0, tag_class, parsed_et}, {46'h0, 2'b00, 16'h88E6});
    mk(D, 16'h8100);
    p16(14, 16'h0001);
    p16(16, 16'h88E5);
    p16(18, 16'h0C00);
    p16(20, 16'h0000);
    p16(22, 16'h0001);
    fr(30, 1'b0);
    chk({62'h0, tag_class}, 64'h0);
    wr(6'h0A, 32'h1);
    fr(30, 1'b0);
    chk({62'h0, tag_class}, 64'h1);
    wr(6'h0C, 32'h5);
    wr(6'h0D, 32'h00000030);
    mk(D, 16'h8100);
    p16(14, 16'hA123);
    p16(16, 16'h0800);
    fr(30, 1'b1);
    vchk({4'b1010, 3'h5, 12'h123, 16'h0800});
    mk(D, 16'h0800);
    fr(30, 1'b0);
    vchk({4'b0000, 3'h2, 12'h000, 16'h0800});
    mk(D, 16'h88A8);
    p16(14, 16'h6456);
    p16(16, 16'h8100);
    p16(18, 16'h3789);
    p16(20, 16'h86DD);
    fr(30, 1'b0);
    vchk({4'b1101, 3'h3, 12'h456, 16'h86DD});
    chk({49'h0, inner_up, inner_vid}, {49'h0, 3'h6, 12'h789});
    wr(6'h0C, 32'h4);
    fr(30, 1'b0);
    vchk({4'b1101, 3'h2, 12'h456, 16'h86DD});
    wr(6'h0B, 32'h1);
    fr(30, 1'b0);
    vchk({4'b0000, 3'h2, 12'h000, 16'h88A8});
    close_out;
  end
  initial begin
    #500000;
    n_mismatch++;
    close_out;
  end
endmodule
bind fsc_classifier fsc_classifier_checker u_fsc_classifier_checker (.clk, .rst, .avs_read,
  .avs_write, .avs_waitrequest, .rx_valid, .rx_data, .rx_sop, .rx_eop, .res_valid,
  .ctl_frame, .tag_class, .kay_bypass, .vlan_valid, .stag_valid, .qtag_valid, .qinq_found,
  .parsed_et);
`default_nettype wire
